// file: rtl/acs_defines.svh
// Functional notes
// R1: Ignore control inputs until chip-select settling passes
// R2: Host waits settling time before shifting bits
// R3: No valid conversions before system register written
// R4: System register write needs eight clocks minimum
// R5: Next cycle loads format register and converts
// R6: Chip select may stay low across cycles
// R7: First valid result shifts out third cycle
// R8: Default mode forces fixed format and channel
// R9: Writing default bit zero leaves default mode
// R10: Valid conversions resume cycle after configuration write
// R11: Early chip-select fall aborts running conversion
// R12: Cycle is conversion plus 8/12/16 clocks
// R13: Eight input bits: command then configuration
// R14: All-ones command loads reference, status, default
// R15: Reset clears registers, status pin high
// R16: Status pin follows end-of-conversion or interrupt mode
// R17: Result valid only after configuration order completes
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
`define ACS_CLK_NS      8
`define ACS_SETTLE_NS   33
`define ACS_SETTLE_CYC  ((`ACS_SETTLE_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_ABORT_NS    1500
`define ACS_ABORT_CYC   (`ACS_ABORT_NS / `ACS_CLK_NS)
`define ACS_CONV_NS     2700
`define ACS_CMD_SYS     4'hF
`define ACS_IN_LAST     5'h07
`define ACS_LEN_8       2'h1
`define ACS_LEN_16      2'h3
`define ACS_N8          5'h08
`define ACS_N12         5'h0C
`define ACS_N16         5'h10
`define ACS_REF_EXT     2'h0
`define ACS_BIP_FLIP    12'h800
`endif

// file: rtl/acs_pkg.sv
package acs_pkg;
    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] cfg;
    } acs_frame_t;
    typedef struct packed {
        logic [1:0] len;
        logic       lsb_first;
        logic       bipolar;
    } acs_fmt_t;
    typedef struct packed {
        logic [1:0] ref_sel;
        logic       int_mode;
        logic       dflt;
    } acs_sys_t;
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_CONV = 2'b01
    } acs_state_t;
endpackage : acs_pkg

// file: rtl/acs_sequencer.sv
`timescale 1ns/1ps
`include "acs_defines.svh"
module acs_sequencer #(
    parameter int CONV_NS = `ACS_CONV_NS
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             io_clk_i,
    input  wire logic             cs_n_i,
    input  wire logic             din_i,
    input  wire logic [11:0]      adc_code_i,
    output logic                  dout_o,
    output logic                  dout_oe_o,
    output logic                  status_o,
    output logic                  sample_o,
    output logic                  busy_o,
    output logic                  result_valid_o,
    output logic [3:0]            channel_o,
    output logic [1:0]            ref_sel_o,
    output acs_pkg::acs_fmt_t     format_config_o,
    output acs_pkg::acs_sys_t     system_config_o,
    output logic [1:0]            cycle_count_o
);
    localparam int CONV_CYC = CONV_NS / `ACS_CLK_NS;
    localparam int SETTLE   = `ACS_SETTLE_CYC;
    localparam int ABORT    = `ACS_ABORT_CYC;

    // Transfer length in I/O clocks
    function automatic logic [4:0] xfer_len(input logic [1:0] len, input logic dflt);
        if (dflt || len == `ACS_LEN_16) begin
            xfer_len = `ACS_N16;
        end else if (len == `ACS_LEN_8) begin
            xfer_len = `ACS_N8;
        end else begin
            xfer_len = `ACS_N12;
        end
    endfunction : xfer_len

    // Result word, first bit to go out at bit 15
    function automatic logic [15:0] out_word(input logic [11:0] code,
                                             input acs_pkg::acs_fmt_t f,
                                             input logic dflt);
        logic [11:0] c;
        logic [11:0] r;
        c = (f.bipolar && !dflt) ? (code ^ `ACS_BIP_FLIP) : code;
        for (int i = 0; i < 12; i++) begin
            r[i] = c[11 - i];
        end
        out_word = (f.lsb_first && !dflt) ? {r, 4'h0} : {c, 4'h0};
    endfunction : out_word

    acs_pkg::acs_fmt_t  fmt_q;
    acs_pkg::acs_sys_t  sys_q;
    acs_pkg::acs_frame_t word_q;
    acs_pkg::acs_state_t state_q;
    logic [4:0]  io_cnt_q;
    logic [7:0]  in_sh_q;
    logic [15:0] out_sh_q;
    logic [15:0] res_q;
    logic [3:0]  tgl_q;
    logic [3:0]  tgl_s1_q;
    logic [3:0]  tgl_s2_q;
    logic [3:0]  tgl_s3_q;
    logic [3:0]  ev;
    logic        cs_s1_q;
    logic        cs_s2_q;
    logic        cs_s3_q;
    logic        cs_fall;
    logic [3:0]  settle_q;
    logic        bad_q;
    logic        sys_wr_q;
    logic        conv_ok_q;
    logic        res_ok_q;
    logic [11:0] conv_cnt_q;
    logic [3:0]  chan_q;
    logic        status_q;
    logic [1:0]  frm_q;
    logic [4:0]  len_io;
    logic        word_ev;
    logic        done_ev;
    logic        first_ev;
    logic        edge_ev;
    logic        go;
    logic        latch;
    logic        abort;
    logic        eoc_mode;

    // Link side: format is quasi-static, changed only between frames
    assign len_io = xfer_len(fmt_q.len, sys_q.dflt);

    // Bit counter restarts whenever chip select is high
    always_ff @(posedge io_clk_i or posedge cs_n_i or negedge rst_n_i) begin
        if (!rst_n_i || cs_n_i) begin
            io_cnt_q <= 5'h00;
        end else if (io_cnt_q == len_io - 5'h01) begin
            io_cnt_q <= 5'h00; // Wraps so chip select may stay low
        end else begin
            io_cnt_q <= io_cnt_q + 5'h01;
        end
    end

    // R13 eight bits in
    always_ff @(posedge io_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_sh_q <= 8'h00;
            word_q  <= '0;
        end else if (io_cnt_q <= `ACS_IN_LAST) begin
            in_sh_q <= {in_sh_q[6:0], din_i};
            if (io_cnt_q == `ACS_IN_LAST) begin
                word_q <= {in_sh_q[6:0], din_i};
            end
        end
    end

    // Event toggles: word, done, first edge, any edge
    always_ff @(posedge io_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tgl_q <= 4'h0;
        end else begin
            tgl_q[0] <= tgl_q[0] ^ (io_cnt_q == `ACS_IN_LAST);
            // R12 frame ends at length
            tgl_q[1] <= tgl_q[1] ^ (io_cnt_q == len_io - 5'h01);
            tgl_q[2] <= tgl_q[2] ^ (io_cnt_q == 5'h00);
            tgl_q[3] <= ~tgl_q[3];
        end
    end

    // Result bits move on falling edges; the held result is stable all frame
    always_ff @(negedge io_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_sh_q <= 16'h0000;
        end else if (io_cnt_q == 5'h01) begin
            out_sh_q <= {res_q[14:0], 1'b0};
        end else begin
            out_sh_q <= {out_sh_q[14:0], 1'b0};
        end
    end

    assign dout_o    = (io_cnt_q == 5'h00) ? res_q[15] : out_sh_q[15];
    assign dout_oe_o = ~cs_n_i;

    // Two-flop crossings into the system clock
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cs_s1_q  <= 1'b1;
            cs_s2_q  <= 1'b1;
            cs_s3_q  <= 1'b1;
            tgl_s1_q <= 4'h0;
            tgl_s2_q <= 4'h0;
            tgl_s3_q <= 4'h0;
        end else begin
            cs_s1_q  <= cs_n_i;
            cs_s2_q  <= cs_s1_q;
            cs_s3_q  <= cs_s2_q;
            tgl_s1_q <= tgl_q;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
        end
    end

    assign ev       = tgl_s2_q ^ tgl_s3_q;
    assign word_ev  = ev[0] && !bad_q;
    assign done_ev  = ev[1] && !bad_q;
    assign first_ev = ev[2];
    assign edge_ev  = ev[3];
    assign cs_fall  = cs_s3_q && !cs_s2_q;

    // R1 settling guard; both paths see equal crossing delay
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || cs_s2_q) begin
            settle_q <= 4'h0;
        end else if (settle_q < 4'(SETTLE)) begin
            settle_q <= settle_q + 4'h1;
        end
    end

    // R2 early clocks void the frame
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            bad_q <= 1'b0;
        end else if (first_ev && settle_q < 4'(SETTLE) && !cs_s2_q) begin
            bad_q <= 1'b1; // Set wins, else a clock with the fall slips through
        end else if (cs_fall) begin
            bad_q <= 1'b0;
        end
    end

    // R14 all-ones command writes system register
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sys_q    <= '0;
            sys_wr_q <= 1'b0;
        end else if (word_ev && word_q.cmd == `ACS_CMD_SYS) begin
            // R4 taken at eighth clock
            // R9 default bit follows data
            sys_q    <= word_q.cfg;
            sys_wr_q <= 1'b1;
        end
    end

    assign go       = done_ev && word_q.cmd != `ACS_CMD_SYS;
    assign abort    = state_q == acs_pkg::ACS_CONV && cs_fall && conv_cnt_q < 12'(ABORT);
    assign latch    = state_q == acs_pkg::ACS_CONV && conv_cnt_q == 12'(CONV_CYC - 1);
    assign eoc_mode = !sys_q.int_mode || sys_q.dflt;

    // R5 format register and channel load
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            fmt_q  <= '0;
            chan_q <= 4'h0;
        end else if (go) begin
            fmt_q  <= word_q.cfg;
            chan_q <= word_q.cmd;
        end
    end

    // Conversion timer on the internal clock
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_q    <= acs_pkg::ACS_IDLE;
            conv_cnt_q <= 12'h000;
            conv_ok_q  <= 1'b0;
        end else begin
            case (state_q)
                acs_pkg::ACS_IDLE: begin
                    conv_cnt_q <= 12'h000;
                    // R10 converts after config write
                    // R6 no chip-select toggle needed
                    if (go) begin
                        state_q   <= acs_pkg::ACS_CONV;
                        conv_ok_q <= sys_wr_q;
                    end
                end
                acs_pkg::ACS_CONV: begin
                    conv_cnt_q <= conv_cnt_q + 12'h001;
                    // R11 abort on early fall
                    if (abort || latch) begin
                        state_q <= acs_pkg::ACS_IDLE;
                    end
                end
                default: state_q <= acs_pkg::ACS_IDLE;
            endcase
        end
    end

    // R15 result register starts cleared
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            res_q    <= 16'h0000;
            res_ok_q <= 1'b0;
        end else if (latch) begin
            res_q    <= out_word(adc_code_i, fmt_q, sys_q.dflt);
            // R3 R17 valid needs order
            res_ok_q <= conv_ok_q;
        end
    end

    // R7 cycles counted from power-up
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            frm_q <= 2'h0;
        end else if (done_ev && frm_q != 2'h3) begin
            frm_q <= frm_q + 2'h1;
        end
    end

    // R16 status pin per mode
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            status_q <= 1'b1;
        end else if (eoc_mode) begin
            status_q <= latch || abort ? 1'b1 : (go ? 1'b0 : status_q);
        end else if (latch) begin
            status_q <= 1'b0; // Latch wins over a clearing edge
        end else if (cs_fall || edge_ev) begin
            status_q <= 1'b1;
        end
    end

    // R8 default mode forces settings
    assign channel_o       = sys_q.dflt ? 4'h0 : chan_q;
    assign ref_sel_o       = sys_q.dflt ? `ACS_REF_EXT : sys_q.ref_sel;
    assign format_config_o = fmt_q;
    assign system_config_o = sys_q;
    assign status_o        = status_q;
    assign sample_o        = go;
    assign busy_o          = state_q == acs_pkg::ACS_CONV;
    assign result_valid_o  = res_ok_q;
    assign cycle_count_o   = frm_q;

    property p_sys_wr;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        word_ev && word_q.cmd == `ACS_CMD_SYS |=> sys_wr_q && sys_q == $past(word_q.cfg);
    endproperty
    a_sys_wr: assert property (p_sys_wr) else $error("system register not written"); // R14
    property p_no_valid;
        @(posedge sys_clk_i) disable iff (!rst_n_i) !sys_wr_q |-> !res_ok_q;
    endproperty
    a_no_valid: assert property (p_no_valid) else $error("valid before config"); // R3
    property p_load;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        go && state_q == acs_pkg::ACS_IDLE |=> busy_o && fmt_q == $past(word_q.cfg);
    endproperty
    a_load: assert property (p_load) else $error("format not loaded"); // R5
    property p_dflt;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        sys_q.dflt |-> channel_o == 4'h0 && len_io == `ACS_N16 && ref_sel_o == `ACS_REF_EXT;
    endproperty
    a_dflt: assert property (p_dflt) else $error("default mode not forced"); // R8
    property p_settle;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        first_ev && !cs_s2_q && settle_q < 4'(SETTLE) |=> bad_q;
    endproperty
    a_settle: assert property (p_settle) else $error("early frame accepted"); // R1
    property p_abort;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        abort |=> !busy_o ##1 $stable(res_q);
    endproperty
    a_abort: assert property (p_abort) else $error("abort ignored"); // R11
    property p_eoc;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        eoc_mode && go && !busy_o ##1 busy_o |-> !status_q;
    endproperty
    a_eoc: assert property (p_eoc) else $error("status not low at start"); // R16
    property p_int;
        @(posedge sys_clk_i) disable iff (!rst_n_i) !eoc_mode && latch |=> !status_q;
    endproperty
    a_int: assert property (p_int) else $error("interrupt not raised"); // R16
    property p_third;
        @(posedge sys_clk_i) disable iff (!rst_n_i) $rose(res_ok_q) |-> frm_q >= 2'h2;
    endproperty
    a_third: assert property (p_third) else $error("valid too early"); // R7
    c_cfg: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) $rose(sys_wr_q));
    c_valid: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) $rose(res_ok_q));
    c_abort: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) abort);
    c_bad: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) $rose(bad_q));
endmodule : acs_sequencer

// file: sim/acs_host_model.sv
`timescale 1ns/1ps
module acs_host_model (
    output logic      io_clk_o,
    output logic      cs_n_o,
    output logic      din_o,
    input  wire logic dout_i
);
    // Link clock stands low outside frames; chip select starts high
    initial begin
        io_clk_o = 1'b0;
        cs_n_o   = 1'b1;
        din_o    = 1'b0;
    end

    // One transfer; early skips the settle wait, rel frees chip select after
    task automatic frame(input logic [7:0] word, input int n_clk, input bit early,
                         input bit rel, output logic [15:0] rx);
        rx = 16'h0000;
        if (cs_n_o) begin
            cs_n_o = 1'b0;
            #(early ? 2 : 48);
        end
        // eight command bits MSB first, then clocks up to length
        for (int i = 0; i < n_clk; i++) begin
            if (i < 8) din_o = word[7 - i];
            #3 io_clk_o = 1'b1;
            rx = {rx[14:0], dout_i};
            #3 io_clk_o = 1'b0;
        end
        // chip select may stay low; a freed line shows the inverse value
        if (rel) begin
            #3 cs_n_o = 1'b1;
            din_o = ~din_o;
            #100;
        end
    endtask : frame

    // Bare chip-select fall, used to abort or to clear the status pin
    task automatic cs_fall;
        cs_n_o = 1'b0;
    endtask : cs_fall
endmodule : acs_host_model

// file: sim/acs_sequencer_tb.sv
`timescale 1ns/1ps
module acs_sequencer_tb;
    logic              sys_clk_i = 1'b0;
    logic              rst_n_i = 1'b1;
    logic [11:0]       adc_code_i = 12'h000;
    logic              io_clk, cs_n, din, dout, dout_oe, status, sample, busy, valid;
    logic [3:0]        channel;
    logic [1:0]        ref_sel, cyc, r2;
    acs_pkg::acs_fmt_t fmt;
    acs_pkg::acs_sys_t sys;
    logic [15:0]       rx;
    logic [11:0]       code;
    logic [3:0]        ch;
    int                n_fail = 0;
    int                total_checks = 0;
    int                n_samples = 0;
    int                s;

    // System clock, 8 ns period
    initial forever #4 sys_clk_i = ~sys_clk_i;

    // Conversion shortened to 100 cycles to keep the run brief
    acs_sequencer #(.CONV_NS(800)) acs_sequencer_inst (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .io_clk_i(io_clk), .cs_n_i(cs_n),
        .din_i(din), .adc_code_i(adc_code_i), .dout_o(dout), .dout_oe_o(dout_oe),
        .status_o(status), .sample_o(sample), .busy_o(busy), .result_valid_o(valid),
        .channel_o(channel), .ref_sel_o(ref_sel), .format_config_o(fmt),
        .system_config_o(sys), .cycle_count_o(cyc));

    acs_host_model acs_host_model_inst (
        .io_clk_o(io_clk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));

    // Count conversion starts; sample is a one-cycle pulse
    always @(posedge sys_clk_i) if (sample === 1'b1) n_samples <= n_samples + 1;

    // Unipolar, MSB first: code then zero padding
    function automatic logic [15:0] exp_word(input logic [11:0] c);
        return {c, 4'h0};
    endfunction : exp_word

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Sample on the falling edge, clear of flop updates
    task automatic cycles(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : cycles

    // Bounded wait for a conversion to start and finish
    task automatic wait_conv;
        int k;
        k = 0;
        while (busy !== 1'b1 && k < 40) begin cycles(1); k++; end
        chk(16'(busy), 16'h0001, "busy start");
        k = 0;
        while (busy !== 1'b0 && k < 200) begin cycles(1); k++; end
        chk(16'(busy), 16'h0000, "busy end");
        cycles(1);
    endtask : wait_conv

    task automatic report_and_stop;
        if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // Watchdog well beyond the expected run of a few microseconds
    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h5B60));
        code = 12'($urandom);
        ch = 4'($urandom_range(10, 0));
        r2 = 2'($urandom);
        // Reset is held over several edges so the synchronous system-side flops see it
        @(posedge sys_clk_i) rst_n_i <= 1'b0;
        cycles(4);
        chk({10'h000, dout_oe, status, 4'(sys)}, 16'h0010, "reset sys");
        chk({11'h000, valid, 4'(fmt)}, 16'h0000, "reset fmt");
        @(posedge sys_clk_i) rst_n_i <= 1'b1;
        cycles(5);
        acs_host_model_inst.frame({4'hF, 4'h1}, 12, 1'b1, 1'b1, rx);
        cycles(6);
        chk(16'(sys), 16'h0000, "early frame");
        // system register first; default forces 16 clocks mid-frame
        acs_host_model_inst.frame({4'hF, r2, 2'b01}, 16, 1'b0, 1'b0, rx);
        cycles(6);
        chk(16'(sys), 16'({r2, 2'b01}), "sys write");
        chk({14'h0000, ref_sel}, 16'h0000, "default ref");
        chk(16'(valid), 16'h0000, "valid early");
        @(posedge sys_clk_i) adc_code_i <= code;
        acs_host_model_inst.frame({ch, 4'hC}, 16, 1'b0, 1'b0, rx);
        wait_conv();
        chk(16'(valid), 16'h0001, "valid");
        chk({12'h000, channel}, 16'h0000, "default channel");
        chk({14'h0000, dout_oe, status}, 16'h0003, "eoc high");
        chk(16'(n_samples), 16'h0001, "samples");
        acs_host_model_inst.frame({4'hF, 4'h4}, 16, 1'b0, 1'b0, rx);
        cycles(6);
        chk(rx, exp_word(code), "result word");
        chk({14'h0000, ref_sel}, 16'h0001, "ref after exit");
        chk(16'(sys), 16'h0004, "default off");
        chk({14'h0000, cyc}, 16'h0003, "frame count");
        // Still a 16-clock frame; the format it loads makes later frames 8 clocks
        acs_host_model_inst.frame({4'h3, 4'h4}, 16, 1'b0, 1'b1, rx);
        cycles(150);
        chk({8'h00, 4'(fmt), channel}, 16'h0043, "format write");
        s = n_samples;
        acs_host_model_inst.frame({4'h5, 4'h4}, 8, 1'b0, 1'b1, rx);
        wait_conv();
        chk(16'(n_samples - s), 16'h0001, "8-clock conversion");
        chk({12'h000, channel}, 16'h0005, "channel");
        acs_host_model_inst.frame({4'h2, 4'h4}, 8, 1'b0, 1'b1, rx);
        chk(16'(busy), 16'h0001, "busy before abort");
        acs_host_model_inst.cs_fall();
        cycles(10);
        chk({14'h0000, busy, status}, 16'h0001, "abort");
        acs_host_model_inst.frame({4'hF, 4'h2}, 8, 1'b0, 1'b0, rx);
        cycles(6);
        chk(16'(sys), 16'h0002, "int mode");
        acs_host_model_inst.frame({4'h1, 4'h4}, 8, 1'b0, 1'b1, rx);
        wait_conv();
        chk(16'(status), 16'h0000, "int low");
        acs_host_model_inst.cs_fall();
        cycles(6);
        chk(16'(status), 16'h0001, "int cleared");
        report_and_stop();
    end
endmodule : acs_sequencer_tb
